//--- logic/scr_pkg.sv
// shared constants and types of the serial cable replacement port
package scr_pkg;

	// system clock
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS = 8;

	// fixed serial settings of the host port
	localparam int unsigned CFG_BAUD = 38400;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned STOP_BITS = 1;
	localparam int unsigned DIV_W = 12;
	// one bit time in clock cycles, rounded down (3255 at 125 MHz)
	localparam logic [DIV_W-1:0] BAUD_DIV = DIV_W'(CLK_HZ / CFG_BAUD);
	localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

	// buffering of host-to-link bytes
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned BYTE_W = 8;

	// voice sample width of the synchronous channel
	localparam int unsigned VOICE_W = 16;

	// handshake lines: bit 0 ring, 1 terminal ready, 2 carrier, 3 set ready (pins 4 to 7)
	localparam int unsigned HS_PIN_BASE = 4;
	localparam int unsigned HS_LINES = 4;
	// lines that the port drives in terminal role
	localparam logic [HS_LINES-1:0] HS_TERM_OUT = 4'h2;

	// serial engine states
	typedef enum logic [1:0] {
		SCR_IDLE,
		SCR_START,
		SCR_DATA,
		SCR_STOP
	} scr_ser_t;

endpackage

//--- logic/scr_fifo.sv
// byte buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module scr_fifo #(
	parameter int unsigned WIDTH = scr_pkg::BYTE_W,
	parameter int unsigned DEPTH = scr_pkg::FIFO_DEPTH
) (
	// clock
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} scr_fifo_st_t;

	scr_fifo_st_t r;
	scr_fifo_st_t n;
	logic push;
	logic pop;

	assign in_ready = ce && (r.cnt != FULL);
	assign out_valid = ce && (r.cnt != '0);
	assign out_data = r.mem[r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = in_data;
			n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
		end
		if (pop) begin
			n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
		end
		// simultaneous push and pop leaves the count alone
		if (push && !pop) begin
			n.cnt = r.cnt + 1'b1;
		end else if (pop && !push) begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	chk_fifo_count_bound: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.cnt <= FULL) else $error("buffer count beyond depth");

endmodule
`default_nettype wire

//--- logic/scr_port.sv
// host side of the wireless serial cable replacement: serial port, link pins, voice and handshake lines
//
// Notes on behaviour
// - one asynchronous data channel and one synchronous voice channel, both full duplex
// - with a link, host bytes and voice pass unchanged to peer and back
// - after reset data passes as soon as a link exists, no setup needed
// - configuration bytes are only taken while no link exists
// - serial port carries configuration without link, payload with link
// - request-to-send is an active-low output, clear-to-send an active-low input
// - disconnect request high tears down the link and refuses new ones
// - link-up output low without link, high once a link is established
// - point-to-point only: a second link is never accepted
// - four handshake lines on pins 4 to 7, active high, role selectable
// - terminal role: ring, carrier, set-ready in, terminal-ready out; modem reversed
// - handshake levels travel to the peer apart from the data channel
// - fixed 38400 baud, 8 data bits, no parity, 1 stop bit, flow control
// - host command mode may only be entered while no link exists
`timescale 1ns/100ps
`default_nettype none
module scr_port #(
	parameter logic [scr_pkg::DIV_W-1:0] CLKS_PER_BIT = scr_pkg::BAUD_DIV,
	parameter int unsigned VW = scr_pkg::VOICE_W,
	parameter int unsigned FIFO_DEPTH = scr_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// host serial port
	input wire logic host_rxd,
	output logic host_txd,
	output logic host_rts_n,
	input wire logic host_cts_n,
	output logic host_overrun,
	output logic host_frame_err,
	// link status pins
	input wire logic disc_req,
	output logic link_up,
	// emulated handshake pins
	input wire logic hs_role_modem,
	input wire logic [scr_pkg::HS_LINES-1:0] hs_pin_i,
	output logic [scr_pkg::HS_LINES-1:0] hs_pin_o,
	output logic [scr_pkg::HS_LINES-1:0] hs_pin_oe,
	// host command mode
	input wire logic cmd_mode_req,
	input wire logic cmd_mode_exit,
	output logic host_command_mode,
	// configuration byte stream to and from the command interpreter
	output logic [7:0] cfg_rx_data,
	output logic cfg_rx_valid,
	input wire logic cfg_rx_ready,
	input wire logic [7:0] cfg_tx_data,
	input wire logic cfg_tx_valid,
	output logic cfg_tx_ready,
	// radio link control
	input wire logic radio_link,
	output logic radio_accept,
	output logic radio_drop,
	// payload towards the peer
	output logic [7:0] peer_tx_data,
	output logic peer_tx_valid,
	input wire logic peer_tx_ready,
	// payload from the peer
	input wire logic [7:0] peer_rx_data,
	input wire logic peer_rx_valid,
	output logic peer_rx_ready,
	// voice samples
	input wire logic [VW-1:0] host_vo_in,
	input wire logic host_vo_in_valid,
	output logic [VW-1:0] host_vo_out,
	output logic host_vo_out_valid,
	output logic [VW-1:0] peer_vo_out,
	output logic peer_vo_out_valid,
	input wire logic [VW-1:0] peer_vo_in,
	input wire logic peer_vo_in_valid,
	// handshake levels to and from the peer
	output logic [scr_pkg::HS_LINES-1:0] peer_hs_out,
	input wire logic [scr_pkg::HS_LINES-1:0] peer_hs_in
);
	localparam int unsigned DW = scr_pkg::DIV_W;
	localparam logic [DW-1:0] BIT_END = CLKS_PER_BIT - 1'b1;
	localparam logic [DW-1:0] HALF_BIT = CLKS_PER_BIT >> 1;

	typedef struct packed {
		logic link;
		logic cmd_mode;
		logic drop;
		logic allow;
		scr_pkg::scr_ser_t tx_st;
		logic [DW-1:0] tx_div;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_low;
		scr_pkg::scr_ser_t rx_st;
		logic [DW-1:0] rx_div;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_vld;
		logic ovr;
		logic ferr;
		logic [VW-1:0] vo_to_peer;
		logic vo_to_peer_v;
		logic [VW-1:0] vo_to_host;
		logic vo_to_host_v;
		logic [scr_pkg::HS_LINES-1:0] hs_to_peer;
		logic [scr_pkg::HS_LINES-1:0] hs_to_host;
	} scr_st_t;

	scr_st_t r;
	scr_st_t n;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic tx_free;
	logic tx_take;
	logic tx_tick;
	logic rx_tick;
	logic [scr_pkg::HS_LINES-1:0] hs_dir;

	// received bytes wait here; a full buffer stops the host through request-to-send
	scr_fifo #(
		.WIDTH(scr_pkg::BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.in_valid(r.rx_vld),
		.in_data(r.rx_sh),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_out_ready)
	);

	assign host_rts_n = !fifo_in_ready;

	// byte routing depends only on link state, no setup step needed
	assign peer_tx_valid = fifo_out_valid && r.link;
	assign cfg_rx_valid = fifo_out_valid && !r.link;
	assign peer_tx_data = fifo_out_data;
	assign cfg_rx_data = fifo_out_data;
	assign fifo_out_ready = r.link ? peer_tx_ready : cfg_rx_ready;

	// a character only starts while clear-to-send is asserted
	assign tx_free = ce && (r.tx_st == scr_pkg::SCR_IDLE) && !host_cts_n;
	assign peer_rx_ready = tx_free && r.link;
	assign cfg_tx_ready = tx_free && !r.link;
	assign tx_take = r.link ? (peer_rx_valid && peer_rx_ready) : (cfg_tx_valid && cfg_tx_ready);
	assign tx_tick = (r.tx_div == BIT_END);
	assign rx_tick = (r.rx_div == BIT_END);

	assign host_txd = !r.tx_low;
	assign host_overrun = r.ovr;
	assign host_frame_err = r.ferr;
	assign link_up = r.link;
	assign host_command_mode = r.cmd_mode;
	assign radio_accept = r.allow;
	assign radio_drop = r.drop;
	assign peer_vo_out = r.vo_to_peer;
	assign peer_vo_out_valid = r.vo_to_peer_v;
	assign host_vo_out = r.vo_to_host;
	assign host_vo_out_valid = r.vo_to_host_v;
	assign peer_hs_out = r.hs_to_peer;

	// direction per handshake line: the role flips every line
	for (genvar i = 0; i < scr_pkg::HS_LINES; i++) begin : g_hs
		assign hs_dir[i] = hs_role_modem ^ scr_pkg::HS_TERM_OUT[i];
		assign hs_pin_oe[i] = hs_dir[i];
		assign hs_pin_o[i] = r.hs_to_host[i] && hs_dir[i];
	end

	always_comb begin
		n = r;
		n.rx_vld = 1'b0;
		n.ferr = 1'b0;
		// a completed byte that meets a full buffer is lost and flagged
		n.ovr = r.rx_vld && !fifo_in_ready;

		n.link = radio_link;
		n.drop = disc_req && radio_link;
		// never offer a second link while one is up
		n.allow = !disc_req && !radio_link;
		if (radio_link) begin
			n.cmd_mode = 1'b0;
		end else if (cmd_mode_req) begin
			n.cmd_mode = 1'b1;
		end else if (cmd_mode_exit) begin
			n.cmd_mode = 1'b0;
		end

		// transmitter
		if (r.tx_st != scr_pkg::SCR_IDLE) begin
			n.tx_div = tx_tick ? '0 : r.tx_div + 1'b1;
		end
		unique case (r.tx_st)
			scr_pkg::SCR_IDLE: begin
				if (tx_take) begin
					n.tx_st = scr_pkg::SCR_START;
					n.tx_low = 1'b1;
					n.tx_div = '0;
					n.tx_sh = r.link ? peer_rx_data : cfg_tx_data;
				end
			end
			scr_pkg::SCR_START: begin
				if (tx_tick) begin
					n.tx_st = scr_pkg::SCR_DATA;
					n.tx_bit = '0;
					n.tx_low = !r.tx_sh[0];
					n.tx_sh = r.tx_sh >> 1;
				end
			end
			scr_pkg::SCR_DATA: begin
				if (tx_tick) begin
					if (r.tx_bit == scr_pkg::LAST_BIT) begin
						n.tx_st = scr_pkg::SCR_STOP;
						n.tx_low = 1'b0;
					end else begin
						n.tx_bit = r.tx_bit + 1'b1;
						n.tx_low = !r.tx_sh[0];
						n.tx_sh = r.tx_sh >> 1;
					end
				end
			end
			scr_pkg::SCR_STOP: begin
				if (tx_tick) begin
					n.tx_st = scr_pkg::SCR_IDLE;
				end
			end
		endcase

		// receiver: start bit checked at its middle, later bits sampled a full bit apart
		if (r.rx_st != scr_pkg::SCR_IDLE) begin
			n.rx_div = r.rx_div + 1'b1;
		end
		unique case (r.rx_st)
			scr_pkg::SCR_IDLE: begin
				if (!host_rxd) begin
					n.rx_st = scr_pkg::SCR_START;
					n.rx_div = '0;
				end
			end
			scr_pkg::SCR_START: begin
				if (r.rx_div == HALF_BIT) begin
					// a glitch shorter than half a bit is not a character
					n.rx_st = host_rxd ? scr_pkg::SCR_IDLE : scr_pkg::SCR_DATA;
					n.rx_div = '0;
					n.rx_bit = '0;
				end
			end
			scr_pkg::SCR_DATA: begin
				if (rx_tick) begin
					n.rx_div = '0;
					n.rx_sh = {host_rxd, r.rx_sh[7:1]};
					if (r.rx_bit == scr_pkg::LAST_BIT) begin
						n.rx_st = scr_pkg::SCR_STOP;
					end else begin
						n.rx_bit = r.rx_bit + 1'b1;
					end
				end
			end
			scr_pkg::SCR_STOP: begin
				if (rx_tick) begin
					n.rx_div = '0;
					n.rx_st = scr_pkg::SCR_IDLE;
					n.rx_vld = host_rxd;
					n.ferr = !host_rxd;
				end
			end
		endcase

		// voice runs beside the data channel, both directions
		n.vo_to_peer_v = host_vo_in_valid && r.link;
		if (host_vo_in_valid) begin
			n.vo_to_peer = host_vo_in;
		end
		n.vo_to_host_v = peer_vo_in_valid && r.link;
		if (peer_vo_in_valid) begin
			n.vo_to_host = peer_vo_in;
		end

		// handshake levels bypass the byte path entirely
		n.hs_to_peer = hs_pin_i & ~hs_dir;
		n.hs_to_host = r.link ? peer_hs_in : '0;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_tx_take;
		ce && tx_take;
	endsequence

	sequence s_link_seen;
		ce && radio_link;
	endsequence

	property p_start_bit;
		s_tx_take |=> !host_txd ##1 !host_txd;
	endproperty

	chk_link_up_follow: assert property (s_link_seen |=> link_up)
		else $error("link-up output missed an established link");

	chk_link_down_low: assert property (ce && !radio_link |=> !link_up)
		else $error("link-up output high without a link");

	chk_cmd_mode_gate: assert property (link_up |-> !host_command_mode)
		else $error("command mode while a link exists");

	chk_cfg_only_unlinked: assert property (cfg_rx_valid |-> !link_up)
		else $error("configuration byte offered during a link");

	chk_payload_only_linked: assert property (peer_tx_valid |-> link_up)
		else $error("payload byte offered without a link");

	chk_cts_pause: assert property (host_cts_n |-> !peer_rx_ready && !cfg_tx_ready)
		else $error("transmit accepted while clear-to-send is off");

	chk_disc_refuse: assert property (ce && disc_req |=> !radio_accept)
		else $error("link offered during disconnect request");

	chk_disc_drop: assert property (ce && disc_req && radio_link |=> radio_drop)
		else $error("disconnect request did not drop the link");

	chk_single_link: assert property (ce && radio_link |=> !radio_accept)
		else $error("second link offered while linked");

	chk_start_bit_low: assert property (p_start_bit)
		else $error("character did not begin with a low start bit");

	chk_line_idle_high: assert property (r.tx_st == scr_pkg::SCR_IDLE |-> host_txd)
		else $error("transmit line not high while idle");

	chk_voice_forward: assert property (ce && r.link && host_vo_in_valid
		|=> peer_vo_out_valid && peer_vo_out == $past(host_vo_in))
		else $error("voice sample not forwarded unchanged");

	chk_hs_direction: assert property (hs_pin_oe == (hs_role_modem ? 4'hD : 4'h2))
		else $error("handshake line direction wrong for role");

	chk_hs_to_peer: assert property (ce && !hs_role_modem
		|=> peer_hs_out == ($past(hs_pin_i) & 4'hD))
		else $error("handshake input level not passed to peer");

endmodule
`default_nettype wire

//--- verif/scr_host_model.sv
// host terminal model: sends and receives 8N1 characters on the serial port
`timescale 1ns/100ps
`default_nettype none
module scr_host_model #(
	parameter int BIT_CLKS = 16
) (
	// clock
	input wire logic sys_clk,
	// serial lines
	input wire logic host_txd,
	output logic host_rxd,
	output logic host_cts_n,
	// bench control
	input wire logic pause
);
	logic [7:0] rx_byte;
	int rx_count = 0;
	initial host_rxd = 1'b1;
	assign host_cts_n = pause;
	// a low stop bit makes a framing error; the line goes back high as soon as the full-length stop bit ends
	task automatic send(input logic [7:0] b, input logic stop = 1'b1);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			host_rxd <= f[i];
			repeat (BIT_CLKS - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		host_rxd <= 1'b1;
		// hand back off the clock edge so the caller reads settled outputs
		#1;
	endtask
	// a low stop bit leaves the count unchanged, so the bench sees a missing byte
	initial begin
		forever begin
			@(posedge sys_clk);
			if (host_txd === 1'b0) begin
				repeat (BIT_CLKS / 2) @(posedge sys_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CLKS) @(posedge sys_clk);
					rx_byte[i] = host_txd;
				end
				repeat (BIT_CLKS) @(posedge sys_clk);
				if (host_txd === 1'b1) rx_count++;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/scr_bench.sv
// self-checking bench of the serial cable replacement port
`timescale 1ns/100ps
`default_nettype none
module serial_cable_replacement_port_bench;
	logic sys_clk = 0, sys_rst = 1, ce = 1, host_rxd, host_txd, host_rts_n, host_cts_n, pause = 0;
	logic host_overrun, host_frame_err, disc_req = 0, link_up, hs_role_modem = 0;
	logic [3:0] hs_pin_i = 4'h0, hs_pin_o, hs_pin_oe, peer_hs_out, peer_hs_in = 4'h0, oe;
	logic cmd_mode_req = 0, cmd_mode_exit = 0, host_command_mode, cfg_rx_valid, cfg_rx_ready = 0;
	logic [7:0] cfg_rx_data, cfg_tx_data = 8'h00, peer_tx_data, peer_rx_data = 8'h00, b;
	logic cfg_tx_valid = 0, cfg_tx_ready, radio_link = 0, radio_accept, radio_drop;
	logic peer_tx_valid, peer_tx_ready = 0, peer_rx_valid = 0, peer_rx_ready;
	logic [15:0] host_vo_in = 16'h0000, host_vo_out, peer_vo_out, peer_vo_in = 16'h0000;
	logic host_vo_in_valid = 0, host_vo_out_valid, peer_vo_out_valid, peer_vo_in_valid = 0;
	logic [7:0] q [8];
	int failures = 0, n_checks = 0, w;
	logic ferr_seen = 0, ovr_seen = 0;
	scr_port #(.CLKS_PER_BIT(12'h010)) scr_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
		.host_rxd(host_rxd), .host_txd(host_txd), .host_rts_n(host_rts_n), .host_cts_n(host_cts_n),
		.host_overrun(host_overrun), .host_frame_err(host_frame_err), .disc_req(disc_req), .link_up(link_up),
		.hs_role_modem(hs_role_modem), .hs_pin_i(hs_pin_i), .hs_pin_o(hs_pin_o), .hs_pin_oe(hs_pin_oe),
		.cmd_mode_req(cmd_mode_req), .cmd_mode_exit(cmd_mode_exit), .host_command_mode(host_command_mode),
		.cfg_rx_data(cfg_rx_data), .cfg_rx_valid(cfg_rx_valid), .cfg_rx_ready(cfg_rx_ready),
		.cfg_tx_data(cfg_tx_data), .cfg_tx_valid(cfg_tx_valid), .cfg_tx_ready(cfg_tx_ready),
		.radio_link(radio_link), .radio_accept(radio_accept), .radio_drop(radio_drop),
		.peer_tx_data(peer_tx_data), .peer_tx_valid(peer_tx_valid), .peer_tx_ready(peer_tx_ready),
		.peer_rx_data(peer_rx_data), .peer_rx_valid(peer_rx_valid), .peer_rx_ready(peer_rx_ready),
		.host_vo_in(host_vo_in), .host_vo_in_valid(host_vo_in_valid), .host_vo_out(host_vo_out),
		.host_vo_out_valid(host_vo_out_valid), .peer_vo_out(peer_vo_out), .peer_vo_out_valid(peer_vo_out_valid),
		.peer_vo_in(peer_vo_in), .peer_vo_in_valid(peer_vo_in_valid), .peer_hs_out(peer_hs_out),
		.peer_hs_in(peer_hs_in));
	scr_host_model #(.BIT_CLKS(16)) scr_host_model_inst (.sys_clk(sys_clk), .host_txd(host_txd),
		.host_rxd(host_rxd), .host_cts_n(host_cts_n), .pause(pause));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// error outputs are one-cycle pulses, so they are caught here and checked later
	always @(posedge sys_clk) begin
		if (host_frame_err === 1'b1) ferr_seen <= 1'b1;
		if (host_overrun === 1'b1) ovr_seen <= 1'b1;
	end
	// drives land one step after the edge, so outputs read here are settled
	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one byte towards the host: configuration reply unlinked, peer byte linked
	task automatic to_host(input logic [7:0] d, input logic lnk);
		int c;
		c = scr_host_model_inst.rx_count;
		if (lnk) {peer_rx_data, peer_rx_valid} <= {d, 1'b1};
		else {cfg_tx_data, cfg_tx_valid} <= {d, 1'b1};
		// let the new request and clear-to-send settle before ready is judged
		#1;
		for (w = 0; w < 40 && (lnk ? peer_rx_ready : cfg_tx_ready) !== 1'b1; w++) tick();
		tick();
		{peer_rx_valid, cfg_tx_valid} <= 2'b00;
		for (w = 0; w < 400 && scr_host_model_inst.rx_count == c; w++) tick();
		check("host byte", {8'h00, scr_host_model_inst.rx_byte}, {8'h00, d});
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(32'h8654));
		tick(16);
		sys_rst <= 0;
		tick(2);
		check("idle", {11'h0, link_up, host_txd, host_rts_n, radio_accept, host_command_mode}, 16'h0A);
		b = 8'($urandom);
		scr_host_model_inst.send(b);
		for (w = 0; w < 40 && cfg_rx_valid !== 1'b1; w++) tick();
		check("cfg rx", {8'h00, cfg_rx_data}, {8'h00, b});
		cfg_rx_ready <= 1;
		tick();
		cfg_rx_ready <= 0;
		scr_host_model_inst.send(8'($urandom), 1'b0);
		tick(4);
		check("frame err", {14'h0, ferr_seen, cfg_rx_valid}, 16'h2);
		pause <= 1;
		cfg_tx_valid <= 1;
		tick(5);
		check("cts pause", {15'h0, cfg_tx_ready}, 16'h0);
		pause <= 0;
		to_host(8'($urandom), 0);
		cmd_mode_req <= 1;
		tick();
		cmd_mode_req <= 0;
		tick(2);
		check("cmd mode", {15'h0, host_command_mode}, 16'h1);
		cmd_mode_exit <= 1;
		tick();
		cmd_mode_exit <= 0;
		tick(2);
		check("cmd exit", {15'h0, host_command_mode}, 16'h0);
		cmd_mode_req <= 1;
		tick();
		cmd_mode_req <= 0;
		tick(2);
		check("cmd again", {15'h0, host_command_mode}, 16'h1);
		radio_link <= 1;
		tick(2);
		check("linked", {13'h0, link_up, radio_accept, host_command_mode}, 16'h4);
		cmd_mode_req <= 1;
		tick();
		cmd_mode_req <= 0;
		tick(2);
		check("no cmd linked", {15'h0, host_command_mode}, 16'h0);
		// fill the buffer while the link stalls, then drain in order
		for (int i = 0; i < 8; i++) begin
			q[i] = 8'($urandom);
			scr_host_model_inst.send(q[i]);
		end
		tick(20);
		check("rts full", {14'h0, ovr_seen, host_rts_n}, 16'h1);
		// a ninth character while full is lost and flagged; the buffer keeps the first eight
		scr_host_model_inst.send(8'($urandom));
		tick(4);
		check("overrun", {14'h0, ovr_seen, host_rts_n}, 16'h3);
		peer_tx_ready <= 1;
		for (int i = 0; i < 8; i++) begin
			for (w = 0; w < 40 && peer_tx_valid !== 1'b1; w++) tick();
			check("peer tx", {8'h00, peer_tx_data}, {8'h00, q[i]});
			tick();
		end
		to_host(8'($urandom), 1);
		{host_vo_in, peer_vo_in} <= {16'($urandom), 16'($urandom)};
		{host_vo_in_valid, peer_vo_in_valid} <= 2'b11;
		tick(2);
		check("vo peer", peer_vo_out, host_vo_in);
		check("vo host", host_vo_out, peer_vo_in);
		check("vo valid", {host_vo_out_valid, peer_vo_out_valid}, 16'h3);
		{host_vo_in_valid, peer_vo_in_valid} <= 2'b00;
		for (int r = 0; r < 2; r++) begin
			hs_role_modem <= r[0];
			{hs_pin_i, peer_hs_in} <= 8'($urandom);
			tick(3);
			oe = r[0] ? 4'hD : 4'h2;
			check("hs oe", {12'h0, hs_pin_oe}, {12'h0, oe});
			check("hs to peer", {12'h0, peer_hs_out}, {12'h0, hs_pin_i & ~oe});
			check("hs from peer", {12'h0, hs_pin_o & oe}, {12'h0, peer_hs_in & oe});
		end
		disc_req <= 1;
		tick(2);
		check("disc", {14'h0, radio_drop, radio_accept}, 16'h2);
		radio_link <= 0;
		tick(2);
		check("refuse", {14'h0, link_up, radio_accept}, 16'h0);
		disc_req <= 0;
		tick(2);
		check("accept", {14'h0, link_up, radio_accept}, 16'h1);
		// clock enable low freezes the link state and closes the buffer
		ce <= 0;
		radio_link <= 1;
		tick(3);
		check("ce freeze", {14'h0, link_up, host_rts_n}, 16'h1);
		ce <= 1;
		tick(2);
		check("ce run", {14'h0, link_up, host_rts_n}, 16'h2);
		// second reset in mid-run
		sys_rst <= 1;
		radio_link <= 0;
		tick(2);
		check("in reset", {11'h0, link_up, host_txd, host_rts_n, radio_accept, radio_drop}, 16'h08);
		sys_rst <= 0;
		tick(2);
		check("after reset", {13'h0, link_up, radio_accept, host_command_mode}, 16'h2);
		summarize();
	end
endmodule
`default_nettype wire
